// ### core/pmw_ctrl.sv
// Purpose: Power-mode, wake and soft-reset control registers of the monitor
// Assumes: Register port driven by the serial interface logic on mclk
// Notes:   conv_done comes from the measurement logic on mclk
`timescale 1ns/1ns
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter int unsigned MS_CYCLES = PMW_MS_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        load_detect_pin,
  input  wire logic        charger_detect_pin,
  input  wire logic        current_above_threshold,
  input  wire logic        conv_done,
  output logic             conv_start,
  output pmw_mode_t        mode,
  output logic             soft_reset_pulse,
  output logic             fet_drive_clear,
  output logic             ext_regulator_enable,
  output logic             ext_reg_low_power,
  output logic             supply55_low_power,
  output logic      [4:0]  irq_enable
);
  pmw_timer_if tif ();

  logic [15:0]         pwr_q;
  logic [15:0]         inten_q;
  logic [PMW_NPIN-1:0] pin_lvl;
  pmw_mode_t           state_q;
  pmw_mode_t           state_d;
  pmw_mode_t           base;
  logic                wr_pwr;
  logic                wr_inten;
  logic                wr_trig;
  logic                soft_rst;
  logic                wake_clr;
  logic                sleep_wake;
  logic                stb_wake;
  logic                low_mode;
  logic                act_like;
  logic                intm_mode;
  logic                trig_q;
  logic                intm_pend_q;
  logic                busy_q;
  logic                start_d;
  logic [1:0]          scheme;

  pmw_pin_sync u_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pin_raw ({current_above_threshold, charger_detect_pin, load_detect_pin}),
    .pin_lvl (pin_lvl)
  );

  pmw_wake_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tif   (tif)
  );

  assign wr_pwr   = reg_wr && reg_addr == PMW_ADDR_PWR;
  assign wr_inten = reg_wr && reg_addr == PMW_ADDR_INTEN;
  assign wr_trig  = reg_wr && reg_addr == PMW_ADDR_TRIG;
  assign scheme   = pwr_q[PMW_SCH_HI:PMW_SCH_LO];
  assign low_mode = state_q == PMW_STANDBY || state_q == PMW_LOWPOW;
  assign act_like = state_q == PMW_ACTIVE || state_q == PMW_LOWPOW;
  assign mode     = state_q;

  assign soft_rst = wr_pwr && !reg_wdata[PMW_SOFT];

  assign sleep_wake = (pin_lvl[0] && pwr_q[PMW_LD_SLP]) || (pin_lvl[1] && pwr_q[PMW_CHG_SLP]);
  assign stb_wake = (pin_lvl[0] && pwr_q[PMW_LD_STB]) || (pin_lvl[1] && pwr_q[PMW_CHG_STB]);

  // intermittent only with a scheme chosen
  assign intm_mode = scheme != PMW_SCH_NONE && (low_mode || state_q == PMW_INTM);

  assign tif.run     = low_mode && scheme != PMW_SCH_NONE;
  assign tif.restart = scheme == PMW_SCH_NOCOMM && (reg_wr || reg_rd);

  always_comb
  begin
    if (scheme == PMW_SCH_NOCOMM)
      tif.delay_ms = PMW_NOCOMM_MS;
    else if (scheme == PMW_SCH_TIMED)
      tif.delay_ms = PMW_WDLY_BASE_MS << pwr_q[PMW_WDLY_HI:PMW_WDLY_LO];
    else
      tif.delay_ms = PMW_ADLY_BASE_MS << pwr_q[PMW_ADLY_HI:PMW_ADLY_LO];
  end

  // mode held by the request bits
  always_comb
  begin
    if (pwr_q[PMW_STB])
      base = PMW_STANDBY;
    else if (pwr_q[PMW_LP])
      base = PMW_LOWPOW;
    else
      base = PMW_ACTIVE;
  end

  always_comb
  begin
    state_d  = state_q;
    wake_clr = 1'b0;
    case (state_q)
      PMW_SHUTDN:
        if (!pwr_q[PMW_SHDN])
          state_d = base;
      PMW_SLEEP:
        if (pwr_q[PMW_SHDN])
          state_d = PMW_SHUTDN;
        else if (sleep_wake)
        begin
          state_d  = PMW_ACTIVE;
          wake_clr = 1'b1;
        end
        else if (!pwr_q[PMW_SLP])
          state_d = base;
      PMW_INTM:
        if (pwr_q[PMW_SHDN])
          state_d = PMW_SHUTDN;
        else if (pwr_q[PMW_SLP])
          state_d = PMW_SLEEP;
        else if (stb_wake)
        begin
          state_d  = PMW_ACTIVE;
          wake_clr = 1'b1;
        end
        else if (conv_done && busy_q)
          state_d = base;
      default:
        if (pwr_q[PMW_SHDN])
          state_d = PMW_SHUTDN;
        else if (pwr_q[PMW_SLP])
          state_d = PMW_SLEEP;
        else if (low_mode && stb_wake)
        begin
          state_d  = PMW_ACTIVE;
          wake_clr = 1'b1;
        end
        else if (tif.run && tif.expired && scheme == PMW_SCH_AUTO)
        begin
          // Sense current above threshold ends the auto scheme
          if (pin_lvl[2])
          begin
            state_d  = PMW_ACTIVE;
            wake_clr = 1'b1;
          end
        end
        else if (tif.run && tif.expired)
          state_d = PMW_INTM;
        else
          state_d = base;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      state_q <= PMW_ACTIVE;
    else
      state_q <= state_d;
  end

  // control register, soft reset bit never holds zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b || soft_rst)
      pwr_q <= PMW_PWR_RST;
    else if (wr_pwr)
      pwr_q <= reg_wdata | PMW_SOFT_SET;
    else if (wake_clr)
      pwr_q <= pwr_q & ~PMW_REQ_CLR;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b || soft_rst)
      inten_q <= PMW_INTEN_RST;
    else if (wr_inten)
      inten_q <= reg_wdata & PMW_INTEN_WMASK;
  end

  // trigger pending, a new trigger wins over the clear
  always_ff @(posedge mclk)
  begin
    if (!rst_b || soft_rst)
      trig_q <= 1'b0;
    else if (wr_trig && reg_wdata[PMW_TRIG_BIT])
      trig_q <= 1'b1;
    else if (start_d && act_like)
      trig_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      intm_pend_q <= 1'b0;
    else if (state_d == PMW_INTM && state_q != PMW_INTM)
      intm_pend_q <= 1'b1;
    else if (start_d || state_q != PMW_INTM)
      intm_pend_q <= 1'b0;
  end

  assign start_d = !busy_q && !conv_start
                && ((act_like && (pwr_q[PMW_CONT] || trig_q))
                    || (state_q == PMW_INTM && intm_pend_q));

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      conv_start <= 1'b0;
    else
      conv_start <= start_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      busy_q <= 1'b0;
    else if (start_d)
      busy_q <= 1'b1;
    else if (conv_done)
      busy_q <= 1'b0;
  end

  // FET drive clear on sleep entry
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      fet_drive_clear <= 1'b0;
    else
      fet_drive_clear <= state_d == PMW_SLEEP && state_q != PMW_SLEEP
                      && inten_q[PMW_FET_CLR];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      soft_reset_pulse <= 1'b0;
    else
      soft_reset_pulse <= soft_rst;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ext_regulator_enable <= 1'b0;
      irq_enable           <= 5'h00;
    end
    else
    begin
      ext_regulator_enable <= inten_q[PMW_REGEN];
      irq_enable           <= inten_q[PMW_IRQ_HI:PMW_IRQ_LO];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ext_reg_low_power  <= 1'b0;
      supply55_low_power <= 1'b0;
    end
    else if (intm_mode)
    begin
      ext_reg_low_power  <= inten_q[PMW_XLP_INTM];
      supply55_low_power <= inten_q[PMW_SLP_INTM];
    end
    else if (low_mode)
    begin
      ext_reg_low_power  <= inten_q[PMW_XLP_STB];
      supply55_low_power <= inten_q[PMW_SLP_STB];
    end
    else if (state_q == PMW_SLEEP)
    begin
      ext_reg_low_power  <= inten_q[PMW_XLP_SLP];
      supply55_low_power <= inten_q[PMW_SLP_SLP];
    end
    else
    begin
      ext_reg_low_power  <= 1'b0;
      supply55_low_power <= 1'b0;
    end
  end

  // Read port, unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_addr == PMW_ADDR_PWR)
        reg_rdata <= pwr_q;
      else if (reg_addr == PMW_ADDR_INTEN)
        reg_rdata <= inten_q;
      else
        reg_rdata <= 16'h0000;
    end
  end

  property p_soft_default;
    @(posedge mclk) disable iff (!rst_b)
    soft_rst |=> pwr_q == PMW_PWR_RST && inten_q == PMW_INTEN_RST;
  endproperty
  a_soft_default: assert property (p_soft_default)
    else $error("soft reset did not restore defaults");

  property p_soft_self_set;
    @(posedge mclk) disable iff (!rst_b)
    wr_pwr |=> pwr_q[PMW_SOFT] ##1 pwr_q[PMW_SOFT];
  endproperty
  a_soft_self_set: assert property (p_soft_self_set)
    else $error("soft reset bit not back at one");

  property p_ro_bits;
    @(posedge mclk) disable iff (!rst_b)
    wr_inten |=> (inten_q & ~PMW_INTEN_WMASK) == 16'h0000;
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("read-only enable bits took a write");

  property p_cont;
    @(posedge mclk) disable iff (!rst_b)
    state_q == PMW_ACTIVE && pwr_q[PMW_CONT] && !busy_q && !conv_start |=> conv_start;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous conversion not restarted");

  property p_single;
    @(posedge mclk) disable iff (!rst_b)
    $rose(conv_start) && !$past(pwr_q[PMW_CONT]) && $past(state_q) != PMW_INTM
      |-> $past(trig_q);
  endproperty
  a_single: assert property (p_single)
    else $error("conversion without trigger");

  property p_shutdown;
    @(posedge mclk) disable iff (!rst_b)
    pwr_q[PMW_SHDN] |=> state_q == PMW_SHUTDN;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown request not obeyed");

  property p_sleep;
    @(posedge mclk) disable iff (!rst_b)
    pwr_q[PMW_SLP] && !pwr_q[PMW_SHDN] && state_q == PMW_ACTIVE |=> state_q == PMW_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request not obeyed");

  property p_standby;
    @(posedge mclk) disable iff (!rst_b)
    pwr_q[PMW_STB] && pwr_q[PMW_SLP:PMW_SHDN] == 2'h0 && state_q == PMW_ACTIVE && !stb_wake
      |=> state_q == PMW_STANDBY;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby request not obeyed");

  property p_load_sleep_wake;
    @(posedge mclk) disable iff (!rst_b)
    state_q == PMW_SLEEP && !pwr_q[PMW_SHDN] && pin_lvl[0] && pwr_q[PMW_LD_SLP]
      |=> state_q == PMW_ACTIVE ##1 (!pwr_q[PMW_SLP] || $past(wr_pwr) || $past(wr_pwr, 2));
  endproperty
  a_load_sleep_wake: assert property (p_load_sleep_wake)
    else $error("load detect did not wake from sleep");

  property p_chg_stb_wake;
    @(posedge mclk) disable iff (!rst_b)
    low_mode && pwr_q[PMW_SLP:PMW_SHDN] == 2'h0 && pin_lvl[1] && pwr_q[PMW_CHG_STB]
      |=> state_q == PMW_ACTIVE;
  endproperty
  a_chg_stb_wake: assert property (p_chg_stb_wake)
    else $error("charger detect did not wake from standby");

  property p_no_intm;
    @(posedge mclk) disable iff (!rst_b)
    scheme == PMW_SCH_NONE && state_q != PMW_INTM |=> state_q != PMW_INTM;
  endproperty
  a_no_intm: assert property (p_no_intm)
    else $error("intermittent check with no scheme");

  property p_fet_clear;
    @(posedge mclk) disable iff (!rst_b)
    state_q == PMW_SLEEP && $past(state_q) != PMW_SLEEP
      |-> fet_drive_clear == $past(inten_q[PMW_FET_CLR]);
  endproperty
  a_fet_clear: assert property (p_fet_clear)
    else $error("FET clear on sleep entry wrong");
endmodule

// ### pkg/pmw_pkg.sv
// Purpose: Shared constants and types of the power-mode and wake control block
// Assumes: 10 MHz mclk, 16-bit registers
// Notes:   Register offsets, field positions, reset values and delays live here
package pmw_pkg;
  // Register offsets
  localparam logic [7:0]  PMW_ADDR_PWR     = 8'h01;
  localparam logic [7:0]  PMW_ADDR_INTEN   = 8'h02;
  localparam logic [7:0]  PMW_ADDR_TRIG    = 8'h0c;
  localparam int          PMW_TRIG_BIT     = 0;
  // Power-mode control fields
  localparam int          PMW_CONT         = 15;
  localparam int          PMW_WDLY_HI      = 14;
  localparam int          PMW_WDLY_LO      = 13;
  localparam int          PMW_SCH_HI       = 12;
  localparam int          PMW_SCH_LO       = 11;
  localparam int          PMW_LD_SLP       = 10;
  localparam int          PMW_CHG_SLP      = 9;
  localparam int          PMW_LD_STB       = 8;
  localparam int          PMW_CHG_STB      = 7;
  localparam int          PMW_ADLY_HI      = 6;
  localparam int          PMW_ADLY_LO      = 5;
  localparam int          PMW_STB          = 4;
  localparam int          PMW_LP           = 3;
  localparam int          PMW_SLP          = 2;
  localparam int          PMW_SHDN         = 1;
  localparam int          PMW_SOFT         = 0;
  localparam logic [15:0] PMW_PWR_RST      = 16'h0781;
  localparam logic [15:0] PMW_REQ_CLR      = 16'h001c;
  localparam logic [15:0] PMW_SOFT_SET     = 16'h0001;
  // Interrupt enable and regulator fields
  localparam int          PMW_IRQ_HI       = 15;
  localparam int          PMW_IRQ_LO       = 11;
  localparam int          PMW_FET_CLR      = 10;
  localparam int          PMW_REGEN        = 8;
  localparam int          PMW_XLP_STB      = 6;
  localparam int          PMW_XLP_SLP      = 5;
  localparam int          PMW_XLP_INTM     = 4;
  localparam int          PMW_SLP_STB      = 3;
  localparam int          PMW_SLP_SLP      = 2;
  localparam int          PMW_SLP_INTM     = 1;
  localparam logic [15:0] PMW_INTEN_RST    = 16'h0500;
  localparam logic [15:0] PMW_INTEN_WMASK  = 16'hfd7f;
  // Intermittent schemes
  localparam logic [1:0]  PMW_SCH_NONE     = 2'h0;
  localparam logic [1:0]  PMW_SCH_NOCOMM   = 2'h1;
  localparam logic [1:0]  PMW_SCH_TIMED    = 2'h2;
  localparam logic [1:0]  PMW_SCH_AUTO     = 2'h3;
  // Timing
  localparam int          PMW_CLK_NS       = 100;
  localparam int          PMW_MS_NS        = 1000000;
  localparam int          PMW_MS_CYCLES    = PMW_MS_NS / PMW_CLK_NS;
  localparam int          PMW_NOCOMM_S     = 1;
  localparam logic [9:0]  PMW_NOCOMM_MS    = 10'(PMW_NOCOMM_S * 1000);
  localparam logic [9:0]  PMW_WDLY_BASE_MS = 10'h014;
  localparam logic [9:0]  PMW_ADLY_BASE_MS = 10'h00a;
  localparam int          PMW_NPIN         = 3;
  typedef enum logic [2:0] {
    PMW_ACTIVE  = 3'h0,
    PMW_LOWPOW  = 3'h1,
    PMW_STANDBY = 3'h3,
    PMW_INTM    = 3'h2,
    PMW_SLEEP   = 3'h6,
    PMW_SHUTDN  = 3'h7
  } pmw_mode_t;
endpackage

// ### pkg/pmw_timer_if.sv
// Purpose: Link between the mode controller and its wake timer
// Assumes: Both ends on mclk
// Notes:   Delay is in milliseconds
`timescale 1ns/1ns
interface pmw_timer_if;
  logic       run;
  logic       restart;
  logic [9:0] delay_ms;
  logic       expired;
  modport ctrl (output run, output restart, output delay_ms, input expired);
  modport tmr  (input run, input restart, input delay_ms, output expired);
endinterface

// ### core/pmw_pin_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for the wake pins
// Assumes: Pins are asynchronous to mclk
// Notes:   Level follows once the second and third stages agree
`timescale 1ns/1ns
module pmw_pin_sync
  import pmw_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic [PMW_NPIN-1:0] pin_raw,
  output logic      [PMW_NPIN-1:0] pin_lvl
);
  logic [PMW_NPIN-1:0] s1_q;
  logic [PMW_NPIN-1:0] s2_q;
  logic [PMW_NPIN-1:0] s3_q;

  for (genvar i = 0; i < PMW_NPIN; i++)
  begin : g_pin
    always_ff @(posedge mclk)
    begin
      if (!rst_b)
      begin
        s1_q[i]    <= 1'b0;
        s2_q[i]    <= 1'b0;
        s3_q[i]    <= 1'b0;
        pin_lvl[i] <= 1'b0;
      end
      else
      begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
          pin_lvl[i] <= s3_q[i];
      end
    end
  end
endmodule

// ### core/pmw_wake_timer.sv
// Purpose: Millisecond wake timer for the intermittent schemes
// Assumes: delay_ms is at least 1
// Notes:   Restarts itself after each expiry while run holds
`timescale 1ns/1ns
module pmw_wake_timer
  import pmw_pkg::*;
#(
  parameter int unsigned MS_CYCLES = PMW_MS_CYCLES
)
(
  input  wire logic    mclk,
  input  wire logic    rst_b,
  pmw_timer_if.tmr     tif
);
  logic [15:0] pre_q;
  logic [9:0]  ms_q;
  logic        exp_q;
  logic        tick;
  logic        last;
  logic        hold;

  assign tick        = pre_q == 16'(MS_CYCLES - 1);
  assign last        = ms_q == 10'(tif.delay_ms - 10'h001);
  assign hold        = !tif.run || tif.restart;
  assign tif.expired = exp_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_b || hold || tick)
      pre_q <= 16'h0000;
    else
      pre_q <= pre_q + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b || hold)
      ms_q <= 10'h000;
    else if (tick)
      ms_q <= last ? 10'h000 : ms_q + 10'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      exp_q <= 1'b0;
    else
      exp_q <= !hold && tick && last;
  end
endmodule

// ### testbench/pmw_host_model.sv
// Purpose: Host side of the register port, issuing single-word reads and writes
// Assumes: Requests launched and released on falling mclk
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module pmw_host_model (
  input  wire logic        mclk,
  input  wire logic [15:0] reg_rdata,
  output logic      [7:0]  reg_addr  = 8'h00,
  output logic      [15:0] reg_wdata = 16'h0000,
  output logic             reg_wr    = 1'b0,
  output logic             reg_rd    = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

// ### testbench/pmw_ctrl_tb_top.sv
// Purpose: Self-checking bench of the power-mode and wake control block
// Assumes: Shortened millisecond of MSC cycles
// Notes:   Timer figures are checked inside a small window
`timescale 1ns/1ns
module pmw_ctrl_tb_top;
  import pmw_pkg::*;
  localparam int MSC = 10;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ld = 1'b0;
  logic        chg = 1'b0;
  logic        cur = 1'b0;
  logic        conv_done = 1'b0;
  wire  [7:0]  reg_addr;
  wire  [15:0] reg_wdata;
  wire         reg_wr;
  wire         reg_rd;
  logic [15:0] reg_rdata;
  logic        conv_start;
  pmw_mode_t   mode;
  logic        soft_reset_pulse;
  logic        fet_drive_clear;
  logic        ext_regulator_enable;
  logic        ext_reg_low_power;
  logic        supply55_low_power;
  logic [4:0]  irq_enable;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_start = 0;
  int          n_fet = 0;
  int          n_soft = 0;
  int          n;
  int          c;
  logic [15:0] d;

  always #50 mclk = ~mclk;

  always @(posedge mclk)
  begin
    n_start += int'(conv_start === 1'b1);
    n_fet   += int'(fet_drive_clear === 1'b1);
    n_soft  += int'(soft_reset_pulse === 1'b1);
  end

  pmw_host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  pmw_ctrl #(.MS_CYCLES(MSC)) u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .load_detect_pin(ld), .charger_detect_pin(chg), .current_above_threshold(cur),
    .conv_done(conv_done), .conv_start(conv_start), .mode(mode),
    .soft_reset_pulse(soft_reset_pulse), .fet_drive_clear(fet_drive_clear),
    .ext_regulator_enable(ext_regulator_enable), .ext_reg_low_power(ext_reg_low_power),
    .supply55_low_power(supply55_low_power), .irq_enable(irq_enable));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wait_mode(input pmw_mode_t m, input int lim, output int cnt);
    cnt = 0;
    while (mode !== m && cnt < lim)
    begin
      @(negedge mclk);
      cnt++;
    end
    chk(16'(mode), 16'(m), "mode wait");
    if (mode !== m)
      give_verdict();
  endtask

  task automatic done_pulse();
    @(negedge mclk);
    conv_done = 1'b1;
    @(negedge mclk);
    conv_done = 1'b0;
  endtask

  initial
  begin
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    u_host.rd(PMW_ADDR_PWR, d);
    chk(d, 16'h0781, "power ctrl default");
    u_host.rd(PMW_ADDR_INTEN, d);
    chk(d, 16'h0500, "enable default");
    u_host.rd(8'h05, d);
    chk(d, 16'h0000, "unmapped read");
    u_host.wr(PMW_ADDR_INTEN, 16'hffff);
    u_host.rd(PMW_ADDR_INTEN, d);
    chk(d, 16'hfd7f, "reserved enable bits");
    chk(16'(irq_enable), 16'h001f, "irq enables");
    chk(16'(ext_regulator_enable), 16'h0001, "regulator on");
    u_host.wr(PMW_ADDR_INTEN, 16'h0448);
    u_host.wr(PMW_ADDR_PWR, 16'h0791);
    wait_mode(PMW_STANDBY, 4, n);
    repeat (2) @(negedge mclk);
    chk(16'(ext_reg_low_power), 16'h0001, "standby low power");
    chk(16'(supply55_low_power), 16'h0001, "standby supply low power");
    chk(16'(ext_regulator_enable), 16'h0000, "regulator off");
    chg = 1'b1;
    wait_mode(PMW_ACTIVE, 10, n);
    chg = 1'b0;
    u_host.rd(PMW_ADDR_PWR, d);
    chk(d, 16'h0781, "wake clears request");
    repeat (6) @(negedge mclk);
    c = n_fet;
    u_host.wr(PMW_ADDR_PWR, 16'h0785);
    wait_mode(PMW_SLEEP, 4, n);
    repeat (4) @(negedge mclk);
    chk(16'(n_fet - c), 16'h0001, "fet clear on sleep");
    ld = 1'b1;
    wait_mode(PMW_ACTIVE, 10, n);
    ld = 1'b0;
    repeat (6) @(negedge mclk);
    u_host.wr(PMW_ADDR_PWR, 16'h0785);
    wait_mode(PMW_SLEEP, 4, n);
    chg = 1'b1;
    wait_mode(PMW_ACTIVE, 10, n);
    chg = 1'b0;
    repeat (6) @(negedge mclk);
    u_host.wr(PMW_ADDR_PWR, 16'h0791);
    wait_mode(PMW_STANDBY, 4, n);
    ld = 1'b1;
    wait_mode(PMW_ACTIVE, 10, n);
    ld = 1'b0;
    repeat (6) @(negedge mclk);
    u_host.wr(PMW_ADDR_PWR, 16'h0611);
    wait_mode(PMW_STANDBY, 4, n);
    ld = 1'b1;
    chg = 1'b1;
    repeat (300) @(negedge mclk);
    chk(16'(mode), 16'(PMW_STANDBY), "wake disabled");
    ld = 1'b0;
    chg = 1'b0;
    repeat (6) @(negedge mclk);
    u_host.wr(PMW_ADDR_PWR, 16'h0783);
    wait_mode(PMW_SHUTDN, 4, n);
    u_host.wr(PMW_ADDR_PWR, 16'h0789);
    wait_mode(PMW_LOWPOW, 4, n);
    u_host.wr(PMW_ADDR_PWR, 16'h0781);
    wait_mode(PMW_ACTIVE, 4, n);
    c = n_start;
    u_host.wr(PMW_ADDR_TRIG, 16'h0001);
    repeat (5) @(negedge mclk);
    chk(16'(n_start - c), 16'h0001, "triggered conversion");
    done_pulse();
    repeat (20) @(negedge mclk);
    chk(16'(n_start - c), 16'h0001, "single conversion");
    u_host.wr(PMW_ADDR_PWR, 16'h8781);
    repeat (5) @(negedge mclk);
    done_pulse();
    repeat (5) @(negedge mclk);
    chk(16'(n_start - c), 16'h0003, "continuous repeats");
    u_host.wr(PMW_ADDR_PWR, 16'h0781);
    done_pulse();
    c = n_soft;
    u_host.wr(PMW_ADDR_INTEN, 16'hffff);
    u_host.wr(PMW_ADDR_PWR, 16'h8790);
    repeat (3) @(negedge mclk);
    chk(16'(n_soft - c), 16'h0001, "soft reset pulse");
    u_host.rd(PMW_ADDR_PWR, d);
    chk(d, 16'h0781, "soft reset bit back to one");
    u_host.rd(PMW_ADDR_INTEN, d);
    chk(d, 16'h0500, "enable restored");
    for (int k = 0; k < 4; k++)
    begin
      u_host.wr(PMW_ADDR_PWR, 16'h1791 | 16'(k << 13));
      wait_mode(PMW_INTM, 2000, n);
      chk(16'(n >= (20 << k) * MSC - 4 && n <= (20 << k) * MSC + 6), 16'h1, "wake delay");
      done_pulse();
      wait_mode(PMW_STANDBY, 4, n);
    end
    cur = 1'b1;
    u_host.wr(PMW_ADDR_PWR, 16'h0781);
    wait_mode(PMW_ACTIVE, 4, n);
    for (int k = 0; k < 4; k++)
    begin
      u_host.wr(PMW_ADDR_PWR, 16'h1f91 | 16'(k << 5));
      wait_mode(PMW_STANDBY, 4, n);
      wait_mode(PMW_ACTIVE, 1000, n);
      chk(16'(n >= (10 << k) * MSC - 6 && n <= (10 << k) * MSC + 6), 16'h1, "auto delay");
    end
    cur = 1'b0;
    u_host.wr(PMW_ADDR_PWR, 16'h0f91);
    wait_mode(PMW_INTM, 10100, n);
    chk(16'(n >= 1000 * MSC - 4 && n <= 1000 * MSC + 6), 16'h1, "no access period");
    done_pulse();
    u_host.wr(PMW_ADDR_PWR, 16'h0781);
    wait_mode(PMW_ACTIVE, 4, n);
    give_verdict();
  end
endmodule
